/* File: rtl/dtm_monitor.v */
// dual-channel torque-off interlock monitor
`timescale 1ns/1ns
`include "dtm_consts.vh"
module dtm_monitor #(
  parameter [`DTM_FILT_W-1:0] TOL_CYC  = `DTM_PULSE_TOL_CYC,
  parameter [`DTM_SKEW_W-1:0] SKEW_CYC = `DTM_SKEW_CYC
) (
  // clock and reset
  input  wire                  mclk,
  input  wire                  rst_n,
  // torque-off channels
  input  wire                  channel_one_input,
  input  wire                  channel_two_input,
  // drive control
  input  wire                  start_cmd,
  input  wire                  stop_cmd,
  input  wire                  fault_reset,
  input  wire [`DTM_CFG_W-1:0] ind_cfg,
  // status
  output reg                   gate_enable_r,
  output reg                   running_r,
  output reg                   channel_one_loss_fault_r,
  output reg                   channel_two_loss_fault_r,
  output reg                   torque_off_ind_r,
  output reg                   start_reject_warn_r,
  output reg                   reset_needed_r
);
  localparam ST_STOP = 1'b0;
  localparam ST_RUN  = 1'b1;

  wire ch1;
  wire ch2;
  reg  state_r;
  reg  [`DTM_SKEW_W-1:0] skew_r;
  reg  start_d_r;
  // filtered loss seen on the previous edge; starts high since channels start open
  reg  lost_d_r;

  // picks the run or the stop half of one config pair
  function cfg_pick;
    input in_run;
    input run_bit;
    input stop_bit;
    begin
      if (in_run) begin
        cfg_pick = run_bit;
      end else begin
        cfg_pick = stop_bit;
      end
    end
  endfunction

  dtm_filter #(.TOL_CYC(TOL_CYC)) u_f1 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .raw_in  (channel_one_input),
    .level_r (ch1)
  );
  dtm_filter #(.TOL_CYC(TOL_CYC)) u_f2 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .raw_in  (channel_two_input),
    .level_r (ch2)
  );

  wire both_ok  = ch1 & ch2;
  wire any_lost = ~both_ok;
  wire one_lost = ch1 ^ ch2;
  wire start_edge = start_cmd & ~start_d_r;
  wire faults   = channel_one_loss_fault_r | channel_two_loss_fault_r | reset_needed_r;
  // mismatch counted only while channels disagree; longer than the allowed skew is a loss
  wire skew_over = one_lost & (skew_r >= SKEW_CYC);
  // the state at the moment of loss picks the selection, not the state after stopping
  wire in_run    = (state_r == ST_RUN);
  wire loss_edge = any_lost & ~lost_d_r;
  wire cfg_rst   = cfg_pick(in_run, ind_cfg[`DTM_CFG_RUN_RST], ind_cfg[`DTM_CFG_STOP_RST]);
  wire cfg_ind   = cfg_pick(in_run, ind_cfg[`DTM_CFG_RUN_IND], ind_cfg[`DTM_CFG_STOP_IND]);

  // loss edge detector; reset value matches the open channels after reset, so no false edge
  always @(posedge mclk) begin
    if (!rst_n) begin
      lost_d_r <= 1'b1;
    end else begin
      lost_d_r <= any_lost;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      skew_r <= {`DTM_SKEW_W{1'b0}};
    end else if (!one_lost) begin
      skew_r <= {`DTM_SKEW_W{1'b0}};
    end else if (!skew_over) begin
      skew_r <= skew_r + 1'b1;
    end
  end

  // interlock path reads ind_cfg only through reset_needed_r, which blocks a start
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r       <= ST_STOP;
      gate_enable_r <= 1'b0;
      running_r     <= 1'b0;
      start_d_r     <= 1'b0;
    end else begin
      start_d_r <= start_cmd;
      case (state_r)
        ST_STOP: begin
          // edge only: a held start never restarts after closing
          if (start_edge && both_ok && !faults) begin
            state_r       <= ST_RUN;
            gate_enable_r <= 1'b1;
            running_r     <= 1'b1;
          end
        end
        default: begin
          if (any_lost || stop_cmd) begin
            state_r       <= ST_STOP;
            gate_enable_r <= 1'b0;
            running_r     <= 1'b0;
          end
        end
      endcase
      if (any_lost) begin
        gate_enable_r <= 1'b0;
      end
    end
  end

  // faults and indications; a set beats a simultaneous reset
  always @(posedge mclk) begin
    if (!rst_n) begin
      channel_one_loss_fault_r <= 1'b0;
      channel_two_loss_fault_r <= 1'b0;
      torque_off_ind_r         <= 1'b0;
      start_reject_warn_r      <= 1'b0;
      reset_needed_r           <= 1'b0;
    end else begin
      if (skew_over && !ch1) begin
        channel_one_loss_fault_r <= 1'b1;
      end else if (fault_reset) begin
        channel_one_loss_fault_r <= 1'b0;
      end
      if (skew_over && !ch2) begin
        channel_two_loss_fault_r <= 1'b1;
      end else if (fault_reset) begin
        channel_two_loss_fault_r <= 1'b0;
      end
      if (loss_edge && cfg_rst) begin
        reset_needed_r <= 1'b1;
      end else if (fault_reset) begin
        reset_needed_r <= 1'b0;
      end
      if (!any_lost) begin
        torque_off_ind_r <= 1'b0;
      end else if (loss_edge) begin
        torque_off_ind_r <= cfg_ind;
      end
      if (start_edge && any_lost && state_r == ST_STOP) begin
        start_reject_warn_r <= 1'b1;
      end else if (both_ok) begin
        start_reject_warn_r <= 1'b0;
      end
    end
  end
endmodule

/* File: rtl/dtm_consts.vh */
// constants for the dual-channel torque-off monitor
`ifndef DTM_CONSTS_VH
`define DTM_CONSTS_VH

`define DTM_CLK_MHZ        250
`define DTM_PULSE_TOL_US   1000
`define DTM_PULSE_TOL_CYC  (`DTM_PULSE_TOL_US * `DTM_CLK_MHZ)
`define DTM_FILT_W         18
`define DTM_SKEW_MS        200
`define DTM_SKEW_CYC       (`DTM_SKEW_MS * 1000 * `DTM_CLK_MHZ)
`define DTM_SKEW_W         26

`define DTM_CFG_W          4
`define DTM_CFG_RUN_IND    0
`define DTM_CFG_STOP_IND   1
`define DTM_CFG_RUN_RST    2
`define DTM_CFG_STOP_RST   3

`endif

/* File: rtl/dtm_filter.v */
// pulse-tolerant filter for one torque-off channel
`timescale 1ns/1ns
`include "dtm_consts.vh"
module dtm_filter #(
  parameter [`DTM_FILT_W-1:0] TOL_CYC = `DTM_PULSE_TOL_CYC
) (
  // clock and reset
  input  wire mclk,
  input  wire rst_n,
  // channel
  input  wire raw_in,
  output reg  level_r
);
  reg  [`DTM_FILT_W-1:0] cnt_r;

  // the level only moves after a deviation lasts longer than the tolerance
  always @(posedge mclk) begin
    if (!rst_n) begin
      level_r <= 1'b0;
      cnt_r   <= {`DTM_FILT_W{1'b0}};
    end else if (raw_in == level_r) begin
      cnt_r <= {`DTM_FILT_W{1'b0}};
    end else if (cnt_r >= TOL_CYC) begin
      level_r <= raw_in;
      cnt_r   <= {`DTM_FILT_W{1'b0}};
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

/* File: test/dtm_checker.sv */
// assertions on the torque-off monitor ports
`timescale 1ns/1ns
module dtm_checker (
  // watched ports
  input wire mclk, rst_n, channel_one_input, channel_two_input, start_cmd, stop_cmd,
  input wire gate_enable_r, start_reject_warn_r, reset_needed_r,
  input wire channel_one_loss_fault_r, channel_two_loss_fault_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire flt_w = channel_one_loss_fault_r | channel_two_loss_fault_r | reset_needed_r;
  a_stop_drops: assert property (stop_cmd && gate_enable_r |=> !gate_enable_r) else $error("stop kept drive");
  a_loss_stops: assert property ((!channel_one_input)[*8] |-> !gate_enable_r) else $error("loss kept drive");
  a_start_edge: assert property ($rose(gate_enable_r) |-> $past(start_cmd) && !$past(start_cmd, 2))
    else $error("run without fresh start");
  a_start_both: assert property ($rose(gate_enable_r) |-> $past(channel_one_input && channel_two_input))
    else $error("run with a channel open");
  a_fall_cause: assert property ($fell(gate_enable_r) && !$past(stop_cmd) |->
    $past(!channel_one_input || !channel_two_input, 2)) else $error("drive dropped on no loss");
  a_fault_off: assert property ($rose(channel_one_loss_fault_r) || $rose(channel_two_loss_fault_r) |->
    !gate_enable_r) else $error("fault while driving");
  a_warn_off: assert property (start_reject_warn_r |-> !gate_enable_r) else $error("warn while driving");
  a_fault_block: assert property (flt_w |=> !$rose(gate_enable_r)) else $error("start despite fault");
  c_start: cover property ($rose(gate_enable_r));
  c_fault: cover property ($rose(channel_one_loss_fault_r));
  c_warn: cover property ($rose(start_reject_warn_r));
endmodule
bind dtm_monitor dtm_checker u_chk (.*);

/* File: test/dtm_contacts.sv */
// switch contact pair driving both channels
`timescale 1ns/1ns
module dtm_contacts (
  input wire       mclk,
  input wire [1:0] want,
  output reg [1:0] ch
);
  initial ch = 2'h0;
  // both contacts move on one edge, far inside the skew limit
  always @(posedge mclk) ch <= want;
endmodule

/* File: test/testbench.sv */
// self-checking bench for the torque-off monitor
`timescale 1ns/1ns
module testbench;
  reg mclk, rst_n, start_cmd, stop_cmd, fault_reset;
  reg [1:0] want, w;
  reg [3:0] ind_cfg;
  reg [31:0] seed;
  wire [1:0] ch;
  wire gate_w, run_w, f1_w, f2_w, ind_w, warn_w, rn_w;
  integer errors, comparisons, i, m;
  dtm_contacts sw (.mclk(mclk), .want(want), .ch(ch));
  dtm_monitor #(.TOL_CYC(4), .SKEW_CYC(20)) uut (.mclk(mclk), .rst_n(rst_n),
    .channel_one_input(ch[0]), .channel_two_input(ch[1]), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .fault_reset(fault_reset), .ind_cfg(ind_cfg), .gate_enable_r(gate_w), .running_r(run_w),
    .channel_one_loss_fault_r(f1_w), .channel_two_loss_fault_r(f2_w), .torque_off_ind_r(ind_w),
    .start_reject_warn_r(warn_w), .reset_needed_r(rn_w));
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  task chk(input [55:0] n, input e, input g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %b got %b", n, e, g);
      end
    end
  endtask
  // c bits: reset, stop, start levels held for n cycles
  task go(input [1:0] k, input [2:0] c, input integer n);
    begin
      @(posedge mclk);
      want <= k;
      {fault_reset, stop_cmd, start_cmd} <= c;
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task results;
    begin
      $display("counts: %0d errors, %0d comparisons", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000 errors = errors + 1;
    results;
  end
  initial begin
    {rst_n, start_cmd, stop_cmd, fault_reset, want, ind_cfg, errors, comparisons} = 0;
    seed = 32'h12;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      m = i % 3;
      w = (m == 0) ? 2'h0 : (m == 1) ? 2'h2 : 2'h1;
      ind_cfg <= seed[3:0];
      go(2'h3, 3'h0, 20);
      go(2'h3, 3'h1, 3);
      chk("run", 1'h1, run_w);
      go(2'h2, 3'h1, 1);
      go(2'h3, 3'h1, 10);
      chk("glitch", 1'h1, run_w);
      go(w, 3'h1, 40);
      chk("run", 1'h0, run_w);
      chk("gate", 1'h0, gate_w);
      chk("fault1", m == 1, f1_w);
      chk("fault2", m == 2, f2_w);
      chk("ind", seed[0], ind_w);
      chk("rstneed", seed[2], rn_w);
      go(w, 3'h0, 2);
      go(w, 3'h1, 3);
      chk("warn", 1'h1, warn_w);
      chk("run", 1'h0, run_w);
      go(2'h3, 3'h0, 10);
      go(2'h3, 3'h1, 3);
      chk("norst", m == 0 && !seed[2], run_w);
      go(2'h3, 3'h0, 2);
      go(2'h3, 3'h4, 3);
      go(2'h3, 3'h1, 3);
      chk("restart", 1'h1, run_w);
      go(2'h3, 3'h2, 3);
      chk("stop", 1'h0, run_w);
      $display("test %0d done", i);
    end
    results;
  end
endmodule
